// ==== pcics_cfg.v ====
// pci command/status configuration word with parity and abort tracking
`timescale 1ns/1ps
`include "pcics_map.vh"
module pcics_cfg (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // configuration access port
  input wire cfg_rd_in,
  input wire cfg_wr_in,
  input wire [5:0] cfg_idx_in,
  input wire [3:0] cfg_be_in,
  input wire [31:0] cfg_wdata_in,
  output reg [31:0] cfg_rdata_out,
  // pci bus signals, synchronous to clk_in
  input wire frame_n_in,
  input wire irdy_n_in,
  input wire trdy_n_in,
  input wire [31:0] ad_in,
  input wire [3:0] cbe_n_in,
  input wire par_in,
  input wire perr_n_in,
  input wire idsel_in,
  // address decode from the base-address logic
  input wire io_hit_in,
  input wire mem_hit_in,
  // master engine status
  input wire mst_act_in,
  input wire mst_rd_in,
  input wire mst_mabort_in,
  input wire mst_tabort_in,
  // driven pci pins
  output reg devsel_n_out,
  output reg devsel_oe_out,
  output reg perr_n_out,
  output reg perr_oe_out,
  output reg serr_n_out,
  output reg serr_oe_out,
  // enables to the rest of the function
  output reg io_en_out,
  output reg mem_en_out,
  output reg bm_en_out
);

  // target sequencer states
  localparam T_IDLE = 3'h0;
  localparam T_WAIT1 = 3'h1;
  localparam T_WAIT2 = 3'h2;
  localparam T_CLAIM = 3'h3;
  localparam T_TURN = 3'h4;

  // command classes returned by the decoder
  localparam C_NONE = 2'h0;
  localparam C_IO = 2'h1;
  localparam C_MEM = 2'h2;
  localparam C_CFG = 2'h3;

  // sorts a bus command into the space it addresses
  function [1:0] cmd_class;
    input [3:0] cmd;
    begin
      case (cmd)
        `PCICS_CMD_IORD, `PCICS_CMD_IOWR: cmd_class = C_IO;
        `PCICS_CMD_MRD, `PCICS_CMD_MWR,
        `PCICS_CMD_MRM, `PCICS_CMD_MRL: cmd_class = C_MEM;
        `PCICS_CMD_CRD, `PCICS_CMD_CWR: cmd_class = C_CFG;
        default: cmd_class = C_NONE;
      endcase
    end
  endfunction

  // read-write command enables
  reg perr_resp; // parity error response
  reg serr_en; // system error driver enable
  // sticky status flags
  reg sts_mdpe; // master data parity error
  reg sts_rta; // received target abort
  reg sts_rma; // received master abort
  reg sts_sse; // signalled system error
  reg sts_dpe; // detected parity error
  // target sequencer
  reg [2:0] t_state;
  reg t_write; // claimed transaction is a write
  reg frame_q; // frame seen asserted last clock
  // parity pipeline, one clock behind the bus
  reg [31:0] ad_q;
  reg [3:0] cbe_q;
  reg chk_vld; // previous clock needs checking
  reg chk_addr; // previous clock was an address phase
  reg chk_perr; // perr may be driven for that phase
  reg chk_mst; // that phase belonged to our master
  reg perr_hold; // perr driven high one clock after

  // decode terms
  wire addr_phase = !frame_n_in && !frame_q;
  wire xfer = !irdy_n_in && !trdy_n_in;
  wire [1:0] cls = cmd_class(cbe_n_in);
  wire par_err = chk_vld && ((^{ad_q, cbe_q}) != par_in);
  wire wr_hit = cfg_wr_in && (cfg_idx_in == `PCICS_IDX_CMDSTAT);

  // claim io and memory only while their enable is set; config is claimed on idsel
  wire claim = (cls == C_IO && io_hit_in && io_en_out) ||
    (cls == C_MEM && mem_hit_in && mem_en_out) ||
    (cls == C_CFG && idsel_in);

  // master read data phase, checked by us
  wire mst_rd_xfer = mst_act_in && mst_rd_in && xfer;
  // target data phase while claimed
  wire tgt_xfer = (t_state == T_CLAIM) && xfer;

  // sticky event terms, set wins over a clearing write
  wire set_dpe = par_err;
  wire set_sse = par_err && chk_addr && serr_en && perr_resp;
  wire set_mdpe = perr_resp && ((par_err && !chk_addr && chk_mst) ||
    (mst_act_in && !mst_rd_in && !perr_n_in));
  wire clr_hi = wr_hit && cfg_be_in[3];

  // command half writes; fixed bits are never stored
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      io_en_out <= `PCICS_RST_IOEN;
      mem_en_out <= `PCICS_RST_MEMEN;
      bm_en_out <= `PCICS_RST_BMEN;
      perr_resp <= `PCICS_RST_PERESP;
      serr_en <= `PCICS_RST_SERREN;
    end else if (wr_hit) begin
      // byte lane 0 holds io, memory, master and parity response
      if (cfg_be_in[0]) begin
        io_en_out <= cfg_wdata_in[`PCICS_B_IOEN];
        mem_en_out <= cfg_wdata_in[`PCICS_B_MEMEN];
        bm_en_out <= cfg_wdata_in[`PCICS_B_BMEN];
        perr_resp <= cfg_wdata_in[`PCICS_B_PERESP];
      end
      // byte lane 1 holds the system error enable
      if (cfg_be_in[1]) begin
        serr_en <= cfg_wdata_in[`PCICS_B_SERREN];
      end
    end
  end

  // sticky status flags: hardware sets, write of one clears
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sts_mdpe <= 1'h0;
      sts_rta <= 1'h0;
      sts_rma <= 1'h0;
      sts_sse <= 1'h0;
      sts_dpe <= 1'h0;
    end else begin
      // a set in the clearing clock keeps the flag, so no event is lost
      sts_dpe <= set_dpe ||
        (sts_dpe && !(clr_hi && cfg_wdata_in[`PCICS_B_DPE]));
      sts_sse <= set_sse ||
        (sts_sse && !(clr_hi && cfg_wdata_in[`PCICS_B_SSE]));
      sts_rma <= mst_mabort_in ||
        (sts_rma && !(clr_hi && cfg_wdata_in[`PCICS_B_RMA]));
      sts_rta <= mst_tabort_in ||
        (sts_rta && !(clr_hi && cfg_wdata_in[`PCICS_B_RTA]));
      sts_mdpe <= set_mdpe ||
        (sts_mdpe && !(clr_hi && cfg_wdata_in[`PCICS_B_MDPE]));
    end
  end

  // read data, registered; fixed fields assembled from constants
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_rdata_out <= 32'h00000000;
    end else if (cfg_rd_in && cfg_idx_in == `PCICS_IDX_CMDSTAT) begin
      // everything not named below reads zero
      cfg_rdata_out <= 32'h00000000;
      cfg_rdata_out[`PCICS_B_IOEN] <= io_en_out;
      cfg_rdata_out[`PCICS_B_MEMEN] <= mem_en_out;
      cfg_rdata_out[`PCICS_B_BMEN] <= bm_en_out;
      cfg_rdata_out[`PCICS_B_MWI] <= 1'h0;
      cfg_rdata_out[`PCICS_B_PERESP] <= perr_resp;
      cfg_rdata_out[`PCICS_B_SERREN] <= serr_en;
      cfg_rdata_out[`PCICS_B_CAPLIST] <= `PCICS_CAPLIST_VAL;
      cfg_rdata_out[`PCICS_B_DEVT_HI:`PCICS_B_DEVT_LO] <=
        `PCICS_DEVT_MEDIUM;
      cfg_rdata_out[`PCICS_B_MDPE] <= sts_mdpe;
      cfg_rdata_out[`PCICS_B_STA] <= 1'h0;
      cfg_rdata_out[`PCICS_B_RTA] <= sts_rta;
      cfg_rdata_out[`PCICS_B_RMA] <= sts_rma;
      cfg_rdata_out[`PCICS_B_SSE] <= sts_sse;
      cfg_rdata_out[`PCICS_B_DPE] <= sts_dpe;
    end else begin
      // other words belong to neighbouring header logic
      cfg_rdata_out <= 32'h00000000;
    end
  end

  // target sequencer: medium decode, devsel after two clocks
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      t_state <= T_IDLE;
      t_write <= 1'h0;
      frame_q <= 1'h0;
      devsel_n_out <= 1'h1;
      devsel_oe_out <= 1'h0;
    end else begin
      frame_q <= !frame_n_in;
      case (t_state)
        T_IDLE: begin
          // address phase seen; our own master never claims itself
          if (addr_phase && claim && !mst_act_in) begin
            t_state <= T_WAIT1;
            t_write <= cbe_n_in[0];
          end
        end
        T_WAIT1: begin
          t_state <= T_WAIT2;
        end
        T_WAIT2: begin
          // second clock after frame was sampled asserted
          t_state <= T_CLAIM;
          devsel_n_out <= 1'h0;
          devsel_oe_out <= 1'h1;
        end
        T_CLAIM: begin
          // last data transfer ends the claim
          if (frame_n_in && xfer) begin
            t_state <= T_TURN;
            devsel_n_out <= 1'h1;
          end
        end
        T_TURN: begin
          // one clock driven high before releasing the line
          t_state <= T_IDLE;
          devsel_oe_out <= 1'h0;
        end
        default: begin
          t_state <= T_IDLE;
          devsel_n_out <= 1'h1;
          devsel_oe_out <= 1'h0;
        end
      endcase
    end
  end

  // capture the phase to be checked; parity trails by one clock
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ad_q <= 32'h00000000;
      cbe_q <= 4'h0;
      chk_vld <= 1'h0;
      chk_addr <= 1'h0;
      chk_perr <= 1'h0;
      chk_mst <= 1'h0;
    end else begin
      ad_q <= ad_in;
      cbe_q <= cbe_n_in;
      // every address phase plus our claimed target transfers and master read transfers
      chk_vld <= addr_phase || tgt_xfer || mst_rd_xfer;
      chk_addr <= addr_phase;
      // perr belongs to the receiver of the data
      chk_perr <= (tgt_xfer && t_write) || mst_rd_xfer;
      chk_mst <= mst_rd_xfer;
    end
  end

  // error pins: perr for data, serr for address parity
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      perr_n_out <= 1'h1;
      perr_oe_out <= 1'h0;
      perr_hold <= 1'h0;
      serr_n_out <= 1'h1;
      serr_oe_out <= 1'h0;
    end else begin
      // perr is sustained tri-state: low, then high for one clock
      if (par_err && !chk_addr && chk_perr && perr_resp) begin
        perr_n_out <= 1'h0;
        perr_oe_out <= 1'h1;
        perr_hold <= 1'h1;
      end else if (perr_hold) begin
        perr_n_out <= 1'h1;
        perr_hold <= 1'h0;
      end else begin
        perr_n_out <= 1'h1;
        perr_oe_out <= 1'h0;
      end
      // serr is open drain: enable only while pulling low
      if (set_sse) begin
        serr_n_out <= 1'h0;
        serr_oe_out <= 1'h1;
      end else begin
        serr_n_out <= 1'h1;
        serr_oe_out <= 1'h0;
      end
    end
  end

endmodule // pcics_cfg

// ==== pcics_map.vh ====
// offsets, field positions, reset values, fixed read values and command codes for pcics
`ifndef PCICS_MAP_VH
`define PCICS_MAP_VH

// dword index of the command/status word in configuration space
`define PCICS_IDX_CMDSTAT 6'h01

// command half, read-write and fixed fields
`define PCICS_B_IOEN 0
`define PCICS_B_MEMEN 1
`define PCICS_B_BMEN 2
`define PCICS_B_MWI 4
`define PCICS_B_PERESP 6
`define PCICS_B_SERREN 8

// status half fields
`define PCICS_B_CAPLIST 20
`define PCICS_B_DEVT_LO 25
`define PCICS_B_DEVT_HI 26
`define PCICS_B_MDPE 24
`define PCICS_B_STA 27
`define PCICS_B_RTA 28
`define PCICS_B_RMA 29
`define PCICS_B_SSE 30
`define PCICS_B_DPE 31

// reset values of the read-write enables
`define PCICS_RST_IOEN 1'h1
`define PCICS_RST_MEMEN 1'h1
`define PCICS_RST_BMEN 1'h1
`define PCICS_RST_PERESP 1'h0
`define PCICS_RST_SERREN 1'h0

// fixed read values
`define PCICS_DEVT_MEDIUM 2'h1
`define PCICS_CAPLIST_VAL 1'h1

// bus command codes carried on the byte-enable lines
`define PCICS_CMD_IORD 4'h2
`define PCICS_CMD_IOWR 4'h3
`define PCICS_CMD_MRD 4'h6
`define PCICS_CMD_MWR 4'h7
`define PCICS_CMD_CRD 4'hA
`define PCICS_CMD_CWR 4'hB
`define PCICS_CMD_MRM 4'hC
`define PCICS_CMD_MRL 4'hE

`endif

// ==== pcics_chk.sv ====
// concurrent checks on the pcics command/status word ports
`timescale 1ns/1ps
module pcics_chk (
  // watched ports, grouped per line to stay compact
  input wire clk_in, input wire rst_n_in,
  input wire cfg_rd_in, input wire cfg_wr_in,
  input wire [5:0] cfg_idx_in, input wire [3:0] cfg_be_in,
  input wire [31:0] cfg_wdata_in, input wire [31:0] cfg_rdata_out,
  input wire frame_n_in, input wire [31:0] ad_in,
  input wire [3:0] cbe_n_in, input wire par_in, input wire idsel_in,
  input wire io_hit_in, input wire mem_hit_in, input wire mst_act_in,
  input wire devsel_n_out, input wire devsel_oe_out,
  input wire perr_n_out, input wire perr_oe_out,
  input wire serr_n_out, input wire serr_oe_out,
  input wire io_en_out, input wire mem_en_out, input wire bm_en_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire [3:0] c = cbe_n_in; // command of a would-be address phase
  // the target must take this address phase
  wire claim = !mst_act_in && ((c[3:1] == 3'h5 && idsel_in) ||
    (c[3:1] == 3'h1 && io_hit_in && io_en_out) || (mem_hit_in &&
    mem_en_out && (c == 4'h6 || c == 4'h7 || c == 4'hC || c == 4'hE)));
  wire wr_me = cfg_wr_in && cfg_idx_in == 6'h01 && cfg_be_in[0];
  // fresh address phase with no claim pending
  sequence s_claim; $fell(frame_n_in) && !devsel_oe_out && claim;
  endsequence
  sequence s_skip; $fell(frame_n_in) && !devsel_oe_out && !claim;
  endsequence
  a_devsel_medium: assert property (s_claim |-> devsel_n_out[*3] ##1
    !devsel_n_out) else $error("devsel not on the medium edge");
  a_unclaimed_quiet: assert property (s_skip |-> !devsel_oe_out[*4])
    else $error("devsel driven for a disabled space");
  a_serr_cause: assert property ($fell(serr_n_out) |->
    $past(frame_n_in, 3) && !$past(frame_n_in, 2) && ($past(par_in) !=
    ^{$past(ad_in, 2), $past(cbe_n_in, 2)})) else $error("serr no cause");
  a_serr_pulse: assert property (serr_oe_out |-> !serr_n_out ##1
    serr_n_out) else $error("serr not a one cycle pulse");
  a_perr_cause: assert property ($fell(perr_n_out) |-> perr_oe_out &&
    $past(par_in) != ^{$past(ad_in, 2), $past(cbe_n_in, 2)})
    else $error("perr without parity error");
  a_en_write: assert property (wr_me |=> {io_en_out, mem_en_out,
    bm_en_out} == {$past(cfg_wdata_in[0]), $past(cfg_wdata_in[1]),
    $past(cfg_wdata_in[2])}) else $error("enables not written");
  a_en_hold: assert property (!wr_me |=> $stable({io_en_out,
    mem_en_out, bm_en_out})) else $error("enables changed unasked");
  a_fixed_bits: assert property (cfg_rd_in && cfg_idx_in == 6'h01 |=>
    (cfg_rdata_out & 32'h0EFFFEB8) == 32'h02100000)
    else $error("fixed fields read wrong");
endmodule // pcics_chk
bind pcics_cfg pcics_chk u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .cfg_rd_in(cfg_rd_in), .cfg_wr_in(cfg_wr_in), .cfg_idx_in(cfg_idx_in),
  .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in),
  .cfg_rdata_out(cfg_rdata_out), .frame_n_in(frame_n_in), .ad_in(ad_in),
  .cbe_n_in(cbe_n_in), .par_in(par_in), .idsel_in(idsel_in),
  .io_hit_in(io_hit_in), .mem_hit_in(mem_hit_in), .mst_act_in(mst_act_in),
  .devsel_n_out(devsel_n_out), .devsel_oe_out(devsel_oe_out),
  .perr_n_out(perr_n_out), .perr_oe_out(perr_oe_out),
  .serr_n_out(serr_n_out), .serr_oe_out(serr_oe_out),
  .io_en_out(io_en_out), .mem_en_out(mem_en_out), .bm_en_out(bm_en_out));

// ==== pcics_bus.sv ====
// model of the other bus agents: initiator, target and master engine
`timescale 1ns/1ps
module pcics_bus (
  // clock and the device's claim pin
  input wire clk_in,
  input wire devsel_n_in,
  // lines toward the device
  output reg frame_n_out, output reg irdy_n_out, output reg trdy_n_out,
  output reg [31:0] ad_out, output reg [3:0] cbe_n_out, output reg par_out,
  output reg idsel_out, output reg perr_drv_out,
  output reg mst_act_out, output reg mst_rd_out
);
  reg flip; // corrupts the next parity bit on request
  integer n; // bounded wait for the claim
  initial begin
    {frame_n_out, irdy_n_out, trdy_n_out, idsel_out} = 4'hE;
    // parity is left to its own clocked process, its only driver
    {perr_drv_out, mst_act_out, mst_rd_out, flip} = 4'h0;
    ad_out = 32'h0;
    cbe_n_out = 4'hF;
  end
  // even parity trails the lines it covers by one clock
  always @(posedge clk_in) par_out <= ^{ad_out, cbe_n_out} ^ flip;
  // one address phase, one data phase; mst marks the device as master
  task xfer(input [3:0] cmd, input [31:0] a, input [31:0] d,
    input bad_a, input bad_d, input mst);
    begin
      @(posedge clk_in);
      frame_n_out <= 1'b0; ad_out <= a; cbe_n_out <= cmd; flip <= bad_a;
      idsel_out <= (cmd[3:1] == 3'h5);
      mst_act_out <= mst;
      mst_rd_out <= mst && !cmd[0];
      @(posedge clk_in);
      frame_n_out <= 1'b1; irdy_n_out <= 1'b0; idsel_out <= 1'b0;
      ad_out <= d; cbe_n_out <= 4'h0; flip <= bad_d;
      n = 0;
      while (!mst && devsel_n_in !== 1'b0 && n < 6) begin
        @(posedge clk_in);
        n = n + 1;
      end
      trdy_n_out <= 1'b0;
      @(posedge clk_in);
      // released lines carry the inverse, not a stale copy
      irdy_n_out <= 1'b1; trdy_n_out <= 1'b1; ad_out <= ~d;
      cbe_n_out <= 4'hF; flip <= 1'b0;
      perr_drv_out <= mst && bad_d && cmd == 4'h7;
      @(posedge clk_in);
      perr_drv_out <= 1'b0; mst_act_out <= 1'b0; mst_rd_out <= 1'b0;
      @(posedge clk_in);
    end
  endtask
endmodule // pcics_bus

// ==== testbench.sv ====
// self-checking bench for the pcics command/status word
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0; reg rst_n = 1'b0; reg rd = 1'b0; reg wr = 1'b0;
  reg [5:0] idx = 6'h01; reg [3:0] be = 4'h0; reg [31:0] wd = 32'h0;
  reg io_hit = 1'b0; reg mem_hit = 1'b0; reg mab = 1'b0; reg tab = 1'b0;
  wire frame_n, irdy_n, trdy_n, par, idsel, perr_drv, mst_act, mst_rd;
  wire [31:0] ad; wire [3:0] cbe_n; wire [31:0] rdata;
  wire devsel_n, devsel_oe, perr_n, perr_oe, serr_n, serr_oe;
  wire io_en, mem_en, bm_en;
  wire perr_w = perr_oe ? perr_n : !perr_drv; // pulled up when idle
  integer errors = 0; integer cmp_count = 0;
  integer perr_cnt = 0; integer serr_cnt = 0;
  always #25 clk = ~clk;
  // count error pin pulses; a pin that never fires is caught by the final count checks
  always @(posedge clk) begin
    if (perr_oe && !perr_n) perr_cnt <= perr_cnt + 1;
    if (serr_oe && !serr_n) serr_cnt <= serr_cnt + 1;
  end
  pcics_cfg DUT (.clk_in(clk), .rst_n_in(rst_n), .cfg_rd_in(rd),
    .cfg_wr_in(wr), .cfg_idx_in(idx), .cfg_be_in(be), .cfg_wdata_in(wd),
    .cfg_rdata_out(rdata), .frame_n_in(frame_n), .irdy_n_in(irdy_n),
    .trdy_n_in(trdy_n), .ad_in(ad), .cbe_n_in(cbe_n), .par_in(par),
    .perr_n_in(perr_w), .idsel_in(idsel), .io_hit_in(io_hit),
    .mem_hit_in(mem_hit), .mst_act_in(mst_act), .mst_rd_in(mst_rd),
    .mst_mabort_in(mab), .mst_tabort_in(tab), .devsel_n_out(devsel_n),
    .devsel_oe_out(devsel_oe), .perr_n_out(perr_n), .perr_oe_out(perr_oe),
    .serr_n_out(serr_n), .serr_oe_out(serr_oe), .io_en_out(io_en),
    .mem_en_out(mem_en), .bm_en_out(bm_en));
  pcics_bus bus (.clk_in(clk), .devsel_n_in(devsel_n), .frame_n_out(frame_n),
    .irdy_n_out(irdy_n), .trdy_n_out(trdy_n), .ad_out(ad),
    .cbe_n_out(cbe_n), .par_out(par), .idsel_out(idsel),
    .perr_drv_out(perr_drv), .mst_act_out(mst_act), .mst_rd_out(mst_rd));
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("unexpected %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // configuration write and read, one strobe cycle each
  task cw(input [5:0] i, input [3:0] b, input [31:0] d);
    begin
      @(posedge clk); wr <= 1'b1; idx <= i; be <= b; wd <= d;
      @(posedge clk); wr <= 1'b0;
    end
  endtask
  task cr(input [5:0] i, input [31:0] e);
    begin
      @(posedge clk); rd <= 1'b1; idx <= i;
      @(posedge clk); rd <= 1'b0;
      #1 chk("word", e, rdata);
    end
  endtask
  task pulse(input m); // m picks master-abort, else target-abort
    begin
      @(posedge clk); mab <= m; tab <= !m;
      @(posedge clk); mab <= 1'b0; tab <= 1'b0;
    end
  endtask
  task complete_run;
    begin
      if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #200000;
    errors = errors + 1;
    complete_run;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    cr(6'h01, 32'h02100007);
    chk("enables", 32'h7, {29'h0, io_en, mem_en, bm_en});
    cw(6'h01, 4'hF, 32'hFFFFFFFF);
    cr(6'h01, 32'h02100147);
    cw(6'h02, 4'hF, 32'h0);
    cr(6'h01, 32'h02100147);
    cr(6'h02, 32'h0);
    @(posedge clk) mem_hit <= 1'b1;
    bus.xfer(4'h7, 32'h00001000, 32'hA5A5A5A5, 1'b1, 1'b1, 1'b0);
    cr(6'h01, 32'hC2100147);
    cw(6'h01, 4'h8, 32'h40000000);
    cr(6'h01, 32'h82100147);
    cw(6'h01, 4'h8, 32'h80000000);
    cr(6'h01, 32'h02100147);
    bus.xfer(4'h6, 32'h00002000, 32'h3C3C3C3C, 1'b0, 1'b1, 1'b1);
    cr(6'h01, 32'h83100147);
    cw(6'h01, 4'h8, 32'hFF000000);
    bus.xfer(4'h7, 32'h00002000, 32'h0F0F0F0F, 1'b0, 1'b1, 1'b1);
    cr(6'h01, 32'h03100147);
    cw(6'h01, 4'h8, 32'hFF000000);
    pulse(1'b1);
    pulse(1'b0);
    cr(6'h01, 32'h32100147);
    cw(6'h01, 4'hB, 32'hFF000007);
    @(posedge clk) io_hit <= 1'b1;
    bus.xfer(4'h2, 32'h00000080, 32'h12345678, 1'b1, 1'b0, 1'b0);
    bus.xfer(4'h6, 32'h00003000, 32'h87654321, 1'b0, 1'b1, 1'b1);
    cr(6'h01, 32'h82100007);
    cw(6'h01, 4'h9, 32'h80000000);
    #1 chk("enables", 32'h0, {29'h0, io_en, mem_en, bm_en});
    bus.xfer(4'h2, 32'h00000080, 32'h11111111, 1'b0, 1'b0, 1'b0);
    bus.xfer(4'h6, 32'h00001000, 32'h22222222, 1'b0, 1'b0, 1'b0);
    cw(6'h01, 4'h1, 32'h00000002);
    bus.xfer(4'h6, 32'h00001000, 32'h33333333, 1'b0, 1'b0, 1'b0);
    bus.xfer(4'hA, 32'h00000004, 32'h44444444, 1'b0, 1'b0, 1'b0);
    cr(6'h01, 32'h02100002);
    chk("perr", 32'h2, perr_cnt);
    chk("serr", 32'h1, serr_cnt);
    complete_run;
  end
endmodule // testbench
